// ---- rtl/pcm_master_defines.vh ----
/*
  Constants for the serial audio bus master: format codes, tone numbers,
  rates and the cycle counts derived from them.
  Assumes a system clock of 250 MHz; all cycle counts are in system clock cycles.
*/
`ifndef PCM_MASTER_DEFINES_VH
`define PCM_MASTER_DEFINES_VH

// =====================================================================
// System clock
`define SYS_CLK_HZ        250000000

// =====================================================================
// Audio formats
`define FMT_VOICE         2'h0
`define FMT_STEREO_LOW    2'h1
`define FMT_STEREO_MID    2'h2
`define FMT_STEREO_HIGH   2'h3

// =====================================================================
// Bit clock rates in Hz and half periods in system cycles
`define VOICE_BCLK_HZ     512000
`define LOW_BCLK_HZ       705000
`define MID_BCLK_HZ       1024000
`define HIGH_BCLK_HZ      1400000
`define VOICE_BCLK_HALF   (`SYS_CLK_HZ / (2 * `VOICE_BCLK_HZ))
`define LOW_BCLK_HALF     (`SYS_CLK_HZ / (2 * `LOW_BCLK_HZ))
`define MID_BCLK_HALF     (`SYS_CLK_HZ / (2 * `MID_BCLK_HZ))
`define HIGH_BCLK_HALF    (`SYS_CLK_HZ / (2 * `HIGH_BCLK_HZ))

// =====================================================================
// Frame rates in Hz (low rate in hundredths, high rate in tenths of Hz) and frame periods
`define VOICE_FS_HZ       8000
`define LOW_FS_CHZ        2005000
`define MID_FS_HZ         32000
`define HIGH_FS_DHZ       441000
`define VOICE_FRAME_CYC   (`SYS_CLK_HZ / `VOICE_FS_HZ)
`define LOW_FRAME_CYC     ((`SYS_CLK_HZ / `LOW_FS_CHZ) * 100)
`define MID_FRAME_CYC     (`SYS_CLK_HZ / `MID_FS_HZ)
`define HIGH_FRAME_CYC    ((`SYS_CLK_HZ / `HIGH_FS_DHZ) * 10)

// =====================================================================
// Word layout and frame slots, counted in bit clock periods
`define WORD_BITS         16
`define VOICE_PAD_BITS    3
`define VOICE_FIRST_BIT   6'h01
`define VOICE_LAST_BIT    6'h10
`define STEREO_RIGHT_BIT  6'h10
`define STEREO_END_BIT    6'h20
`define BIT_CNT_MAX       6'h3f

// =====================================================================
// Ring tone numbers per stereo format
`define TONE_HIGH_A       6'h0a
`define TONE_HIGH_B       6'h0b
`define TONE_HIGH_C       6'h27
`define TONE_HIGH_D       6'h2f
`define TONE_MID_A        6'h30
`define TONE_MID_B        6'h31
`define TONE_LOW_A_FIRST  6'h0c
`define TONE_LOW_A_LAST   6'h26
`define TONE_LOW_B_FIRST  6'h28
`define TONE_LOW_B_LAST   6'h2e

`endif

// ---- rtl/pcm_tick_counter.v ----
/*
  Down counter that gives a one-cycle tick every LOAD system cycles.
  Assumes LOAD is at least 2; a new LOAD takes effect at the next wrap.
*/
`timescale 1ns/1ps

module pcm_tick_counter
(
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Period in cycles
  input  wire [15:0] load,
  // One-cycle tick
  output reg         tick
);

  reg [15:0] cnt_r;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= 16'h0000;
      tick  <= 1'b0;
    end
    else if (cnt_r == 16'h0000)
    begin
      cnt_r <= load - 16'h0001;
      tick  <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r - 16'h0001;
      tick  <= 1'b0;
    end
  end

endmodule // pcm_tick_counter

// ---- rtl/pcm_buf2.v ----
/*
  Two-entry first-in first-out buffer with valid and ready on both sides.
  Assumes both sides on the same clock; in_ready is registered.
*/
`timescale 1ns/1ps

module pcm_buf2
#(
  parameter WIDTH = 16
)
(
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Filling side
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output reg              in_ready,
  // Draining side
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);

  reg [WIDTH-1:0] slot0_r;
  reg [WIDTH-1:0] slot1_r;
  reg [1:0]       count_r;
  reg [1:0]       count_nxt;
  wire            push;
  wire            pop;

  assign push      = in_valid & in_ready;
  assign pop       = out_ready & (count_r != 2'h0);
  assign out_valid = (count_r != 2'h0);
  assign out_data  = slot0_r;

  always @*
  begin
    count_nxt = count_r;
    if (push & ~pop)
      count_nxt = count_r + 2'h1;
    else if (pop & ~push)
      count_nxt = count_r - 2'h1;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slot0_r  <= {WIDTH{1'b0}};
      slot1_r  <= {WIDTH{1'b0}};
      count_r  <= 2'h0;
      in_ready <= 1'b0;
    end
    else
    begin
      count_r  <= count_nxt;
      in_ready <= (count_nxt != 2'h2);
      if (pop)
        slot0_r <= (count_r == 2'h2) ? slot1_r : in_data;
      else if (push & (count_r == 2'h0))
        slot0_r <= in_data;
      if (push & ((count_r == 2'h1 & ~pop) | (count_r == 2'h2)))
        slot1_r <= in_data;
    end
  end

endmodule // pcm_buf2

// ---- rtl/pcm_master.v ----
/*
  Serial audio bus master: drives bit clock, frame sync and serial data out,
  receives serial data in. Voiceband and three stereo ring-tone formats.
  Assumes DIGITAL_SEL and RING_* come from logic on CLK_SYS; SDIN is a pin.
*/
// Contract
// - Device is bus master; it drives bit clock and frame sync.
// - Samples are two's complement linear values both ways.
// - Bus has bit clock out, frame sync out, data out, data in.
// - After power up path is analog; bus toggles; application stays unconnected.
// - Clock and frame rates follow the format currently being sounded.
// - Voiceband runs a 512 kHz bit clock and 8 kHz frame sync.
// - Voiceband word is 13 data bits plus 3 zero bits.
// - Voiceband sync lasts one bit period; then 16 bits both ways.
// - Voiceband frame every 125 us; data idle after the 16 bits.
// - Both data lines preferably high impedance while idle.
// - Bit clock and frame sync toggle continuously, idle time included.
// - Gain settings are not applied while the digital path is selected.
// - Voiceband carries speech and mono tones 6 to 9, default 7.
// - Stereo low tones 12-38, 40-46: 705 kHz clock, 20.05 kHz frames.
// - Stereo mid tones 48, 49: 1024 kHz clock, 32 kHz frames.
// - Stereo high tones 10, 11, 39, 47: 1.4 MHz clock, 44.1 kHz frames.
// - Stereo sends 16-bit words, word-wide sync, ignores data input.
`timescale 1ns/1ps
`include "pcm_master_defines.vh"

module pcm_master
#(
  parameter VOICE_FRAME = `VOICE_FRAME_CYC,
  parameter LOW_FRAME   = `LOW_FRAME_CYC,
  parameter MID_FRAME   = `MID_FRAME_CYC,
  parameter HIGH_FRAME  = `HIGH_FRAME_CYC
)
(
  // Clock and reset
  input  wire        CLK_SYS,
  input  wire        NRST,
  // Path and tone control
  input  wire        DIGITAL_SEL,
  input  wire        RING_ACTIVE,
  input  wire [5:0]  RING_TONE,
  // Samples toward the bus
  input  wire [15:0] TX_DATA,
  input  wire        TX_VALID,
  output wire        TX_READY,
  // Samples from the bus
  output reg  [15:0] RX_DATA,
  output reg         RX_VALID,
  // Status
  output reg         PATH_DIGITAL,
  output reg         GAIN_EN,
  output reg  [1:0]  FRAME_MODE,
  // Bus pins
  output reg         BCLK,
  output reg         FRAME_SYNC,
  output reg         SDOUT,
  output reg         SDOUT_OE,
  input  wire        SDIN
);

  // ===================================================================
  // Format selection from the tone being sounded
  reg [1:0] mode_req;

  always @*
  begin
    mode_req = `FMT_VOICE;
    if (RING_ACTIVE)
    begin
      if (RING_TONE == `TONE_HIGH_A || RING_TONE == `TONE_HIGH_B ||
          RING_TONE == `TONE_HIGH_C || RING_TONE == `TONE_HIGH_D)
        mode_req = `FMT_STEREO_HIGH;
      else if (RING_TONE == `TONE_MID_A || RING_TONE == `TONE_MID_B)
        mode_req = `FMT_STEREO_MID;
      else if ((RING_TONE >= `TONE_LOW_A_FIRST && RING_TONE <= `TONE_LOW_A_LAST) ||
               (RING_TONE >= `TONE_LOW_B_FIRST && RING_TONE <= `TONE_LOW_B_LAST))
        mode_req = `FMT_STEREO_LOW;
    end
  end

  // ===================================================================
  // Rate selection
  reg [1:0]  mode_r;
  reg [15:0] half_load;
  reg [15:0] frame_load;
  wire [31:0] voice_half_w;
  wire [31:0] low_half_w;
  wire [31:0] mid_half_w;
  wire [31:0] high_half_w;

  // Half periods are small; the upper bits are cut on purpose
  assign voice_half_w = `VOICE_BCLK_HALF;
  assign low_half_w   = `LOW_BCLK_HALF;
  assign mid_half_w   = `MID_BCLK_HALF;
  assign high_half_w  = `HIGH_BCLK_HALF;

  always @*
  begin
    case (mode_r)
      `FMT_STEREO_LOW:  half_load = low_half_w[15:0];
      `FMT_STEREO_MID:  half_load = mid_half_w[15:0];
      `FMT_STEREO_HIGH: half_load = high_half_w[15:0];
      default:          half_load = voice_half_w[15:0];
    endcase
    case (mode_req)
      `FMT_STEREO_LOW:  frame_load = LOW_FRAME[15:0];
      `FMT_STEREO_MID:  frame_load = MID_FRAME[15:0];
      `FMT_STEREO_HIGH: frame_load = HIGH_FRAME[15:0];
      default:          frame_load = VOICE_FRAME[15:0];
    endcase
  end

  wire half_tick;
  wire frame_tick;

  pcm_tick_counter u_half
  (
    .clk   (CLK_SYS),
    .rst_n (NRST),
    .load  (half_load),
    .tick  (half_tick)
  );

  pcm_tick_counter u_frame
  (
    .clk   (CLK_SYS),
    .rst_n (NRST),
    .load  (frame_load),
    .tick  (frame_tick)
  );

  // ===================================================================
  // Transmit buffer
  wire [15:0] buf_data;
  wire        buf_valid;
  wire        buf_pop;

  pcm_buf2 #(.WIDTH(`WORD_BITS)) u_txbuf
  (
    .clk       (CLK_SYS),
    .rst_n     (NRST),
    .in_data   (TX_DATA),
    .in_valid  (TX_VALID),
    .in_ready  (TX_READY),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_pop)
  );

  // ===================================================================
  // Input synchroniser
  reg sdin_m_r;
  reg sdin_s_r;

  always @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      sdin_m_r <= 1'b0;
      sdin_s_r <= 1'b0;
    end
    else
    begin
      sdin_m_r <= SDIN;
      sdin_s_r <= sdin_m_r;
    end
  end

  // ===================================================================
  // Frame and bit sequencing
  reg        frame_pend_r;
  reg [5:0]  bit_cnt_r;
  reg [5:0]  bit_cnt_nxt;
  reg [15:0] tx_sh_r;
  reg [15:0] tx_sh_nxt;
  reg [15:0] rx_sh_r;
  reg        digital_r;
  reg        load_word;
  reg        drive_nxt;
  reg        sync_nxt;
  reg        digital_nxt;
  reg [1:0]  mode_nxt;
  reg [15:0] word_in;
  wire       rise;
  wire       fall;
  wire       stereo_nxt;

  assign rise       = half_tick & ~BCLK;
  assign fall       = half_tick & BCLK;
  assign stereo_nxt = (mode_nxt != `FMT_VOICE);

  always @*
  begin
    bit_cnt_nxt = bit_cnt_r;
    mode_nxt    = mode_r;
    digital_nxt = digital_r;
    if (frame_pend_r)
    begin
      bit_cnt_nxt = 6'h00;
      mode_nxt    = mode_req;
      digital_nxt = DIGITAL_SEL;
    end
    else if (bit_cnt_r != `BIT_CNT_MAX)
      bit_cnt_nxt = bit_cnt_r + 6'h01;
  end

  always @*
  begin
    if (stereo_nxt)
    begin
      sync_nxt  = (bit_cnt_nxt < `STEREO_RIGHT_BIT);
      drive_nxt = (bit_cnt_nxt < `STEREO_END_BIT);
      load_word = (bit_cnt_nxt == 6'h00) | (bit_cnt_nxt == `STEREO_RIGHT_BIT);
    end
    else
    begin
      sync_nxt  = (bit_cnt_nxt == 6'h00);
      drive_nxt = (bit_cnt_nxt >= `VOICE_FIRST_BIT) && (bit_cnt_nxt <= `VOICE_LAST_BIT);
      load_word = (bit_cnt_nxt == `VOICE_FIRST_BIT);
    end
    word_in = buf_valid ? buf_data : 16'h0000;
    if (!stereo_nxt)
      word_in = {word_in[15:`VOICE_PAD_BITS], 3'h0};
    tx_sh_nxt = load_word ? word_in : {tx_sh_r[14:0], 1'b0};
  end

  assign buf_pop = rise & load_word & digital_nxt & buf_valid;

  always @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      frame_pend_r <= 1'b0;
      bit_cnt_r    <= `BIT_CNT_MAX;
      mode_r       <= `FMT_VOICE;
      digital_r    <= 1'b0;
      tx_sh_r      <= 16'h0000;
      rx_sh_r      <= 16'h0000;
      BCLK         <= 1'b0;
      FRAME_SYNC   <= 1'b0;
      SDOUT        <= 1'b0;
      SDOUT_OE     <= 1'b0;
      RX_DATA      <= 16'h0000;
      RX_VALID     <= 1'b0;
      PATH_DIGITAL <= 1'b0;
      GAIN_EN      <= 1'b1;
      FRAME_MODE   <= `FMT_VOICE;
    end
    else
    begin
      frame_pend_r <= frame_tick | (frame_pend_r & ~rise);
      RX_VALID     <= 1'b0;
      if (half_tick)
        BCLK <= ~BCLK;
      if (rise)
      begin
        bit_cnt_r    <= bit_cnt_nxt;
        mode_r       <= mode_nxt;
        digital_r    <= digital_nxt;
        tx_sh_r      <= tx_sh_nxt;
        FRAME_SYNC   <= sync_nxt;
        SDOUT        <= digital_nxt & drive_nxt & tx_sh_nxt[15];
        SDOUT_OE     <= digital_nxt & drive_nxt & (DIGITAL_SEL == digital_nxt);
        PATH_DIGITAL <= digital_nxt;
        GAIN_EN      <= ~digital_nxt;
        FRAME_MODE   <= mode_nxt;
      end
      if (fall && digital_r && mode_r == `FMT_VOICE &&
          bit_cnt_r >= `VOICE_FIRST_BIT && bit_cnt_r <= `VOICE_LAST_BIT)
      begin
        rx_sh_r <= {rx_sh_r[14:0], sdin_s_r};
        if (bit_cnt_r == `VOICE_LAST_BIT)
        begin
          RX_DATA  <= {rx_sh_r[14:`VOICE_PAD_BITS-1], 3'h0};
          RX_VALID <= 1'b1;
        end
      end
    end
  end

endmodule // pcm_master

// ---- tb/pcm_codec_model.sv ----
/* Far-side codec model for the serial audio bus master.
   Assumes the master drives bit clock and frame sync. */
`timescale 1ns/1ps

module pcm_codec_model
(
  // Bus pins
  input  wire        bclk,
  input  wire        fsync,
  input  wire        sdout,
  input  wire        sdout_oe,
  output reg         sdin,
  // Word to send, bits seen, connection
  input  wire [15:0] word,
  input  wire        conn,
  output reg  [31:0] cap
);
  reg [5:0] slot_r;
  reg       fs_r;

  initial
  begin
    slot_r = 6'h3f;
    fs_r   = 1'b0;
    sdin   = 1'b0;
    cap    = 32'h0;
  end

  // ==========
  // Slot count and capture at bit clock fall
  always @(negedge bclk)
  begin
    fs_r <= fsync;
    if (fsync && !fs_r)
      slot_r <= 6'h00;
    else if (slot_r != 6'h3f)
      slot_r <= slot_r + 6'h01;
    if (sdout_oe)
      cap <= {cap[30:0], sdout};
  end

  // Released line has no pull, so it wanders
  always @(posedge bclk)
    if (conn && slot_r <= 6'h0f)
      sdin <= word[4'hf - slot_r[3:0]];
    else
      sdin <= ~sdin;
endmodule // pcm_codec_model

// ---- tb/pcm_master_chk.sv ----
/* Port checker for the serial audio bus master.
   Assumes the shared defines header and the bind below. */
`timescale 1ns/1ps
`include "pcm_master_defines.vh"

module pcm_master_chk
#(
  parameter VOICE_FRAME = 31250
)
(
  input wire       CLK_SYS,
  input wire       NRST,
  input wire       DIGITAL_SEL,
  input wire       RX_VALID,
  input wire       PATH_DIGITAL,
  input wire       GAIN_EN,
  input wire [1:0] FRAME_MODE,
  input wire       BCLK,
  input wire       FRAME_SYNC,
  input wire       SDOUT_OE
);
  localparam int VH = `VOICE_BCLK_HALF;
  reg [15:0] bh_r, fs_r, oe_r, gap_r;
  reg        seen_r;
  reg [1:0]  lm_r;
  reg [1:0]  fm_r;

  function automatic int half(input logic [1:0] m);
    case (m)
      `FMT_VOICE:      half = `VOICE_BCLK_HALF;
      `FMT_STEREO_LOW: half = `LOW_BCLK_HALF;
      `FMT_STEREO_MID: half = `MID_BCLK_HALF;
      default:         half = `HIGH_BCLK_HALF;
    endcase
  endfunction

  // ==========
  // Run lengths of high levels
  always @(posedge CLK_SYS or negedge NRST)
    if (!NRST)
    begin
      bh_r   <= 16'h0;
      fs_r   <= 16'h0;
      oe_r   <= 16'h0;
      gap_r  <= 16'h0;
      seen_r <= 1'b0;
      lm_r   <= `FMT_VOICE;
      fm_r   <= `FMT_VOICE;
    end
    else
    begin
      bh_r   <= BCLK ? bh_r + 16'h1 : 16'h0;
      fs_r   <= FRAME_SYNC ? fs_r + 16'h1 : 16'h0;
      oe_r   <= SDOUT_OE ? oe_r + 16'h1 : 16'h0;
      gap_r  <= (FRAME_SYNC && fs_r == 16'h0) ? 16'h1 : gap_r + 16'h1;
      seen_r <= seen_r | (FRAME_SYNC && fs_r == 16'h0);
      // High phase after a format change still runs at the old rate
      if (!BCLK)
        lm_r <= FRAME_MODE;
      if (FRAME_SYNC && fs_r == 16'h0)
        fm_r <= lm_r;
    end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  a_bclk_half_time: assert property ($fell(BCLK) |-> bh_r == half(lm_r))
    else $error("bit clock high time wrong");
  a_sync_width: assert property ($fell(FRAME_SYNC)
    |-> fs_r == half(fm_r) + (FRAME_MODE == `FMT_VOICE ? 1 : 31) * half(FRAME_MODE))
    else $error("frame sync width wrong");
  a_voice_frame_gap: assert property (FRAME_SYNC && fs_r == 16'h0 && seen_r && FRAME_MODE == `FMT_VOICE
    |-> gap_r >= VOICE_FRAME - 2 * VH && gap_r <= VOICE_FRAME + 2 * VH)
    else $error("voice frame spacing wrong");
  a_oe_analog_off: assert property (!PATH_DIGITAL && $past(PATH_DIGITAL) == 1'b0 |-> !SDOUT_OE)
    else $error("data driven on analog path");
  a_gain_digital_off: assert property (PATH_DIGITAL && $past(PATH_DIGITAL) |-> !GAIN_EN)
    else $error("gain active on digital path");
  a_oe_after_sync: assert property ($fell(FRAME_SYNC) && FRAME_MODE == `FMT_VOICE && PATH_DIGITAL && DIGITAL_SEL
    |-> SDOUT_OE)
    else $error("data not driven after sync");
  a_voice_data_len: assert property ($fell(SDOUT_OE) && FRAME_MODE == `FMT_VOICE && DIGITAL_SEL
    |-> oe_r == 32 * VH)
    else $error("voice word length wrong");
  a_stereo_no_rx: assert property (FRAME_MODE != `FMT_VOICE && $past(FRAME_MODE) != `FMT_VOICE |-> !RX_VALID)
    else $error("receive in stereo format");

  c_voice_word: cover property ($fell(SDOUT_OE) && FRAME_MODE == `FMT_VOICE);
  c_rx_word: cover property (RX_VALID);
  c_stereo_mid: cover property ($fell(FRAME_SYNC) && FRAME_MODE == `FMT_STEREO_MID);
  c_stereo_high: cover property ($fell(FRAME_SYNC) && FRAME_MODE == `FMT_STEREO_HIGH);
endmodule // pcm_master_chk

bind pcm_master pcm_master_chk #(.VOICE_FRAME(VOICE_FRAME)) pcm_master_chk_inst
(
  .CLK_SYS(CLK_SYS), .NRST(NRST), .DIGITAL_SEL(DIGITAL_SEL), .RX_VALID(RX_VALID),
  .PATH_DIGITAL(PATH_DIGITAL), .GAIN_EN(GAIN_EN), .FRAME_MODE(FRAME_MODE),
  .BCLK(BCLK), .FRAME_SYNC(FRAME_SYNC), .SDOUT_OE(SDOUT_OE)
);

// ---- tb/pcm_master_tb.sv ----
/* Testbench for the serial audio bus master.
   Assumes the codec model and the bound checker. */
`timescale 1ns/1ps
`include "pcm_master_defines.vh"

module pcm_master_tb;
  reg         clk      = 1'b0;
  reg         nrst     = 1'b0;
  reg         dsel     = 1'b0;
  reg         ring     = 1'b0;
  reg  [5:0]  tone     = 6'h07;
  reg  [15:0] tx_data  = 16'h0;
  reg         tx_valid = 1'b0;
  reg  [15:0] word_in  = 16'h0;
  wire        tx_ready, rx_valid, path, gain, bclk, fsync, sdout, sdout_oe, sdin;
  wire [15:0] rx_data;
  wire [1:0]  mode;
  wire [31:0] cap;
  integer     num_errors = 0;
  integer     tests_run  = 0;

  always #2 clk = ~clk;

  pcm_master #(.VOICE_FRAME(9000)) pcm_master_inst
  (
    .CLK_SYS(clk), .NRST(nrst), .DIGITAL_SEL(dsel), .RING_ACTIVE(ring), .RING_TONE(tone),
    .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready), .RX_DATA(rx_data),
    .RX_VALID(rx_valid), .PATH_DIGITAL(path), .GAIN_EN(gain), .FRAME_MODE(mode),
    .BCLK(bclk), .FRAME_SYNC(fsync), .SDOUT(sdout), .SDOUT_OE(sdout_oe), .SDIN(sdin)
  );

  pcm_codec_model pcm_codec_model_inst
  (
    .bclk(bclk), .fsync(fsync), .sdout(sdout), .sdout_oe(sdout_oe), .sdin(sdin),
    .word(word_in), .conn(path), .cap(cap)
  );

  // ==========
  // Shared tasks
  task check(input [31:0] got, input [31:0] exp);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  function hit(input integer s);
    case (s)
      0:       hit = (rx_valid === 1'b1);
      1:       hit = (fsync === 1'b1);
      2:       hit = (fsync === 1'b0);
      default: hit = (path === 1'b1);
    endcase
  endfunction

  task wait_on(input integer s);
    integer n;
  begin
    n = 0;
    @(negedge clk);
    while (!hit(s) && n < 40000)
    begin
      @(negedge clk);
      n = n + 1;
    end
    if (n >= 40000)
      check(n, 0);
  end
  endtask

  task next_frame;
  begin
    wait_on(2);
    wait_on(1);
    wait_on(2);
  end
  endtask

  task push(input [15:0] w);
  begin
    @(posedge clk);
    tx_data  <= w;
    tx_valid <= 1'b1;
    @(negedge clk);
    while (tx_ready !== 1'b1)
      @(negedge clk);
    @(posedge clk);
    tx_valid <= 1'b0;
  end
  endtask

  task set_tone(input [5:0] t, input [1:0] m);
  begin
    @(posedge clk);
    tone <= t;
    next_frame;
    check(mode, m);
  end
  endtask

  // ==========
  // Scenarios
  task t_voice;
  begin
    check(gain, 1);
    @(posedge clk);
    dsel <= 1'b1;
    ring <= 1'b1;
    wait_on(3);
    wait_on(0);
    word_in = 16'hc005;
    push(16'h8001);
    push(16'h7ffe);
    @(negedge clk);
    @(negedge clk);
    check(tx_ready, 0);
    push(16'h1234);
    wait_on(0);
    check(cap[15:0], 16'h8000);
    check(rx_data, 16'hc000);
    check(mode, `FMT_VOICE);
    check(gain, 0);
    word_in = 16'h3ffb;
    wait_on(0);
    check(cap[15:0], 16'h7ff8);
    check(rx_data, 16'h3ff8);
    word_in = 16'h0f0f;
    wait_on(0);
    check(cap[15:0], 16'h1230);
    check(rx_data, 16'h0f08);
    $display("voice test done");
  end
  endtask

  task t_stereo;
  begin
    set_tone(6'h30, `FMT_STEREO_MID);
    push(16'h8421);
    push(16'h7bde);
    wait_on(1);
    wait_on(2);
    wait_on(1);
    check(cap, 32'h84217bde);
    set_tone(6'h2f, `FMT_STEREO_HIGH);
    set_tone(6'h0c, `FMT_STEREO_LOW);
    $display("stereo test done");
  end
  endtask

  task close_out;
  begin
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask

  initial
  begin
    #(90000 * 4);
    num_errors = num_errors + 1;
    close_out;
  end

  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_voice;
    t_stereo;
    close_out;
  end
endmodule // pcm_master_tb
